// >>> design/adcr_pkg.sv
// Constants and types shared by the converter control block
// Behaviour
// R1: Clock codes 001/101/010/110 divide oscillator 8/16/32/64
// R2: Codes x11 use internal RC divided by sixteen
// R3: Clock register: bits 7,3..0 zero, field resets zero
// R4: High result: bits 9..8 in 1..0, rest zero
// R5: Low result: result bits 7..0 in 7..0
// R6: Results read-only, undefined until first conversion
// R7: Software waits acquisition time after channel change
// R8: Go stays high converting, hardware clears when done
// R9: Enable low disables converter, no operating activity; afe.select and afe.src_valid still follow input_select while disabled
// R10: Five-bit select: internal 00..0c, pins 10..17
// R11: Load results, clear go, set done flag
package adcr_pkg;

  // Register byte offsets on the APB bus
  localparam logic [7:0] OFF_CHAN_CTRL = 8'h00;
  localparam logic [7:0] OFF_CLK_CFG = 8'h04;
  localparam logic [7:0] OFF_RES_HIGH = 8'h08;
  localparam logic [7:0] OFF_RES_LOW = 8'h0c;
  localparam logic [7:0] OFF_IRQ_FLAGS = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;

  // Field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_GO_BIT = 1;
  localparam int CTRL_SEL_LSB = 2;
  localparam int CTRL_SEL_MSB = 6;
  localparam int CFG_CS_LSB = 4;
  localparam int CFG_CS_MSB = 6;
  localparam int IRQ_DONE_BIT = 0;
  localparam int RES_W = 10;

  // Reset values and SAR values loaded at conversion start
  localparam logic [4:0] SEL_RST = 5'h00;
  localparam logic [2:0] CS_RST = 3'h0;
  localparam logic MASK_RST = 1'b0;
  localparam logic [9:0] SAR_FIRST = 10'h200;
  localparam logic [3:0] SAR_TOP_IDX = 4'h9;

  // Conversion clock codes and divisors
  localparam logic [2:0] CS_DIV8 = 3'h1;
  localparam logic [2:0] CS_DIV32 = 3'h2;
  localparam logic [2:0] CS_DIV16 = 3'h5;
  localparam logic [2:0] CS_DIV64 = 3'h6;
  localparam logic [2:0] CS_RSVD_A = 3'h0;
  localparam logic [2:0] CS_RSVD_B = 3'h4;
  localparam logic [1:0] CS_RC_LOW = 2'h3;
  localparam logic [6:0] DIV_8 = 7'h08;
  localparam logic [6:0] DIV_16 = 7'h10;
  localparam logic [6:0] DIV_32 = 7'h20;
  localparam logic [6:0] DIV_64 = 7'h40;
  localparam logic [3:0] RC_DIV_LAST = 4'hf;

  // Input select ranges
  localparam logic [4:0] SEL_INT_LAST = 5'h0c;
  localparam logic [4:0] SEL_EXT_FIRST = 5'h10;
  localparam logic [4:0] SEL_EXT_LAST = 5'h17;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_FINISH = 2'b10
  } adcr_state_e;

  // Drive towards the analog front end
  typedef struct packed {
    logic enable;
    logic sample;
    logic src_valid;
    logic [4:0] select;
    logic [9:0] dac;
  } adcr_afe_s;

endpackage

// >>> design/adcr_conv_clk.sv
// Conversion clock tick generator
`timescale 1ns/1ps
`default_nettype none
module adcr_conv_clk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic en,
  input wire logic [2:0] sel,
  input wire logic rc_edge,
  output logic conv_tick
);

  logic [2:0] prev_sel;
  logic [6:0] cnt;
  logic [3:0] rc_cnt;

  // Oscillator divisor per code, zero for reserved codes
  function automatic logic [6:0] divisor(input logic [2:0] code);
    case (code)
      adcr_pkg::CS_DIV8: divisor = adcr_pkg::DIV_8;
      adcr_pkg::CS_DIV16: divisor = adcr_pkg::DIV_16;
      adcr_pkg::CS_DIV32: divisor = adcr_pkg::DIV_32;
      adcr_pkg::CS_DIV64: divisor = adcr_pkg::DIV_64;
      default: divisor = 7'h00;
    endcase
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_sel <= adcr_pkg::CS_RST;
    end else begin
      prev_sel <= sel;
    end
  end

  // Counting restarts on any code change so no short period leaks out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 7'h00;
      rc_cnt <= 4'h0;
      conv_tick <= 1'b0;
    end else if (!en || sel != prev_sel) begin
      cnt <= 7'h00;
      rc_cnt <= 4'h0;
      conv_tick <= 1'b0;
    end else if (sel[1:0] == adcr_pkg::CS_RC_LOW) begin // [R2]
      cnt <= 7'h00;
      conv_tick <= rc_edge && rc_cnt == adcr_pkg::RC_DIV_LAST;
      if (rc_edge) begin
        rc_cnt <= rc_cnt + 4'h1;
      end
    end else if (divisor(sel) == 7'h00) begin // [R1]
      cnt <= 7'h00;
      rc_cnt <= 4'h0;
      conv_tick <= 1'b0;
    end else if (cnt == divisor(sel) - 7'h01) begin // [R1]
      cnt <= 7'h00;
      conv_tick <= 1'b1;
    end else begin
      cnt <= cnt + 7'h01;
      conv_tick <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// >>> design/adcr_top.sv
// Converter control block: APB registers, clock select, SAR sequencer, done interrupt
`timescale 1ns/1ps
`default_nettype none
module adcr_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic comp_in,
  input wire logic rc_osc_in,
  output adcr_pkg::adcr_afe_s afe,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic comp_s1, comp_s2, comp_s3, comp_level;
  logic rc_s1, rc_s2, rc_s3, rc_level;
  logic rc_edge;
  logic conv_tick;
  logic conv_run;
  logic converter_enable;
  logic go;
  logic [4:0] input_select;
  logic [2:0] conv_clock_select;
  logic [9:0] conversion_result;
  logic [9:0] sar;
  logic [9:0] next_sar;
  logic [3:0] bit_idx;
  adcr_pkg::adcr_state_e state;
  logic conv_done_irq_flag;
  logic conv_done_irq_mask;
  logic access;
  logic wr;
  logic wr_ctrl;
  logic setup;
  logic [31:0] rdata;

  function automatic logic addr_mapped(input logic [7:0] a);
    case (a)
      adcr_pkg::OFF_CHAN_CTRL, adcr_pkg::OFF_CLK_CFG, adcr_pkg::OFF_RES_HIGH,
      adcr_pkg::OFF_RES_LOW, adcr_pkg::OFF_IRQ_FLAGS, adcr_pkg::OFF_IRQ_MASK: addr_mapped = 1'b1;
      default: addr_mapped = 1'b0;
    endcase
  endfunction

  function automatic logic select_valid(input logic [4:0] s);
    select_valid = (s <= adcr_pkg::SEL_INT_LAST) ||
      (s >= adcr_pkg::SEL_EXT_FIRST && s <= adcr_pkg::SEL_EXT_LAST);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comp_s1 <= 1'b0;
      comp_s2 <= 1'b0;
      comp_s3 <= 1'b0;
      comp_level <= 1'b0;
    end else begin
      comp_s1 <= comp_in;
      comp_s2 <= comp_s1;
      comp_s3 <= comp_s2;
      if (comp_s2 == comp_s3) begin
        comp_level <= comp_s3;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rc_s1 <= 1'b0;
      rc_s2 <= 1'b0;
      rc_s3 <= 1'b0;
      rc_level <= 1'b0;
    end else begin
      rc_s1 <= rc_osc_in;
      rc_s2 <= rc_s1;
      rc_s3 <= rc_s2;
      if (rc_s2 == rc_s3) begin
        rc_level <= rc_s3;
      end
    end
  end

  assign rc_edge = (rc_s2 == rc_s3) && rc_s3 && !rc_level;

  ////////////////////////////////////////////////////////////////////////////
  // Conversion clock

  // Divider restarts with every conversion except one started by a go write in the finish cycle, so the first decision waits for a settled comparator
  assign conv_run = converter_enable && go; // [R8]

  adcr_conv_clk u_conv_clk (
    .pclk(pclk),
    .presetn(presetn),
    .en(conv_run),
    .sel(conv_clock_select),
    .rc_edge(rc_edge),
    .conv_tick(conv_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: no wait states, data and error prepared in the setup cycle

  assign setup = psel && !penable;
  assign access = psel && penable && pready;
  assign wr = access && pwrite;
  assign wr_ctrl = wr && paddr == adcr_pkg::OFF_CHAN_CTRL;

  always_comb begin
    rdata = 32'h0000_0000;
    case (paddr)
      adcr_pkg::OFF_CHAN_CTRL: rdata = {24'h00_0000, 1'b0, input_select, go, converter_enable};
      adcr_pkg::OFF_CLK_CFG: rdata = {24'h00_0000, 1'b0, conv_clock_select, 4'h0}; // [R3]
      adcr_pkg::OFF_RES_HIGH: rdata = {30'h0000_0000, conversion_result[9:8]}; // [R4]
      adcr_pkg::OFF_RES_LOW: rdata = {24'h00_0000, conversion_result[7:0]}; // [R5]
      adcr_pkg::OFF_IRQ_FLAGS: rdata = {31'h0000_0000, conv_done_irq_flag};
      adcr_pkg::OFF_IRQ_MASK: rdata = {31'h0000_0000, conv_done_irq_mask};
      default: rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup && !addr_mapped(paddr);
      if (setup) begin
        prdata <= pwrite ? 32'h0000_0000 : rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_enable <= 1'b0;
      input_select <= adcr_pkg::SEL_RST;
    end else if (wr_ctrl) begin
      converter_enable <= pwdata[adcr_pkg::CTRL_EN_BIT]; // [R9]
      input_select <= pwdata[adcr_pkg::CTRL_SEL_MSB:adcr_pkg::CTRL_SEL_LSB]; // [R10]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_clock_select <= adcr_pkg::CS_RST;
    end else if (wr && paddr == adcr_pkg::OFF_CLK_CFG) begin
      conv_clock_select <= pwdata[adcr_pkg::CFG_CS_MSB:adcr_pkg::CFG_CS_LSB]; // [R3]
    end
  end

  // Go is only accepted together with enable; a software write beats the hardware clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      go <= 1'b0;
    end else if (wr_ctrl) begin
      go <= pwdata[adcr_pkg::CTRL_GO_BIT] && pwdata[adcr_pkg::CTRL_EN_BIT]; // [R8]
    end else if (!converter_enable || state == adcr_pkg::ST_FINISH) begin
      go <= 1'b0; // [R8] [R11]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Successive approximation sequencer

  always_comb begin
    next_sar = sar;
    next_sar[bit_idx] = comp_level;
    if (bit_idx != 4'h0) begin
      next_sar[bit_idx - 4'h1] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= adcr_pkg::ST_IDLE;
      sar <= 10'h000;
      bit_idx <= 4'h0;
    end else begin
      case (state)
        adcr_pkg::ST_IDLE: begin
          if (go && converter_enable) begin // [R8]
            state <= adcr_pkg::ST_CONV;
            sar <= adcr_pkg::SAR_FIRST;
            bit_idx <= adcr_pkg::SAR_TOP_IDX;
          end
        end
        adcr_pkg::ST_CONV: begin
          if (!go || !converter_enable) begin // [R9]
            state <= adcr_pkg::ST_IDLE;
            sar <= 10'h000;
          end else if (conv_tick) begin
            sar <= next_sar;
            if (bit_idx == 4'h0) begin
              state <= adcr_pkg::ST_FINISH;
            end else begin
              bit_idx <= bit_idx - 4'h1;
            end
          end
        end
        adcr_pkg::ST_FINISH: begin
          state <= adcr_pkg::ST_IDLE;
        end
        default: begin
          state <= adcr_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Result holds no reset value: undefined until the first completion
  always_ff @(posedge pclk) begin
    if (state == adcr_pkg::ST_FINISH) begin
      conversion_result <= sar; // [R6] [R11]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Done interrupt: a completion wins over a write-one clear in the same cycle

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_done_irq_flag <= 1'b0;
    end else if (state == adcr_pkg::ST_FINISH) begin
      conv_done_irq_flag <= 1'b1; // [R11]
    end else if (wr && paddr == adcr_pkg::OFF_IRQ_FLAGS && pwdata[adcr_pkg::IRQ_DONE_BIT]) begin
      conv_done_irq_flag <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_done_irq_mask <= adcr_pkg::MASK_RST;
    end else if (wr && paddr == adcr_pkg::OFF_IRQ_MASK) begin
      conv_done_irq_mask <= pwdata[adcr_pkg::IRQ_DONE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= conv_done_irq_flag && conv_done_irq_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog front end drive; enable, sample and dac idle while disabled, select and src_valid still follow input_select

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      afe <= '0;
    end else begin
      afe.enable <= converter_enable; // [R9]
      afe.sample <= converter_enable && state == adcr_pkg::ST_IDLE; // [R7]
      afe.src_valid <= select_valid(input_select); // [R10]
      afe.select <= input_select; // [R10]
      afe.dac <= (converter_enable && state == adcr_pkg::ST_CONV) ? sar : 10'h000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_div_eight_period: assert property ( // [R1]
    conv_tick && conv_clock_select == adcr_pkg::CS_DIV8 && converter_enable && go
    ##1 (conv_clock_select == adcr_pkg::CS_DIV8 && converter_enable && go) [*8] |-> conv_tick)
    else $error("divide-by-8 tick period wrong");

  a_tick_min_gap: assert property ( // [R1]
    conv_tick |=> (!conv_tick) [*7])
    else $error("conversion ticks closer than eight cycles");

  a_reserved_no_tick: assert property ( // [R1]
    (conv_clock_select == adcr_pkg::CS_RSVD_A || conv_clock_select == adcr_pkg::CS_RSVD_B) [*2]
    |-> !conv_tick)
    else $error("tick produced on a reserved clock code");

  a_rc_tick_source: assert property ( // [R2]
    conv_tick && $past(conv_clock_select[1:0]) == adcr_pkg::CS_RC_LOW |-> $past(rc_edge))
    else $error("internal RC tick without an RC edge");

  a_cfg_readback: assert property ( // [R3]
    setup && !pwrite && paddr == adcr_pkg::OFF_CLK_CFG
    |=> prdata == {24'h00_0000, 1'b0, $past(conv_clock_select), 4'h0})
    else $error("clock config read back wrong");

  a_high_result_read: assert property ( // [R4]
    setup && !pwrite && paddr == adcr_pkg::OFF_RES_HIGH
    |=> prdata[31:2] == 30'h0000_0000 && prdata[1:0] == $past(conversion_result[9:8]))
    else $error("high result read wrong");

  a_low_result_read: assert property ( // [R5]
    setup && !pwrite && paddr == adcr_pkg::OFF_RES_LOW
    |=> prdata == {24'h00_0000, $past(conversion_result[7:0])})
    else $error("low result read wrong");

  a_busy_holds_go: assert property ( // [R8]
    state == adcr_pkg::ST_CONV && $past(state) == adcr_pkg::ST_CONV |-> $past(go))
    else $error("converting without go set");

  a_done_sequence: assert property ( // [R11]
    state == adcr_pkg::ST_FINISH && !wr_ctrl
    |=> !go && conv_done_irq_flag && conversion_result == $past(sar))
    else $error("completion did not load result, clear go and flag");

  a_disabled_quiet: assert property ( // [R9]
    !converter_enable [*2] |=> state == adcr_pkg::ST_IDLE && !afe.enable && afe.dac == 10'h000)
    else $error("converter active while disabled");

  a_select_decode: assert property ( // [R10]
    input_select > adcr_pkg::SEL_EXT_LAST |=> !afe.src_valid)
    else $error("unimplemented select flagged valid");

  a_select_gap_invalid: assert property ( // [R10]
    input_select > adcr_pkg::SEL_INT_LAST && input_select < adcr_pkg::SEL_EXT_FIRST |=> !afe.src_valid)
    else $error("select gap code flagged valid");

  a_irq_level: assert property (
    conv_done_irq_flag && conv_done_irq_mask |=> irq)
    else $error("interrupt not raised");

endmodule
`default_nettype wire

// >>> verification/adcr_tb.sv
// Self-checking testbench for the converter control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module adc_clock_and_result_regs_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic comp_in = 1'b0;
  logic rc_osc_in = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  adcr_pkg::adcr_afe_s afe;
  integer failures = 0;
  integer tests_run = 0;
  integer cyc = 0;
  integer rc_cnt = 0;
  integer seed = 32'he00a16fb;
  integer target = 0;
  integer t0, dur, expv, last, i, s, mask;
  int q[$];
  int codes[6] = '{1, 5, 2, 6, 3, 7};
  int divs[6] = '{8, 16, 32, 64, 96, 96};
  logic [31:0] rd;
  logic er;

  adcr_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .comp_in(comp_in), .rc_osc_in(rc_osc_in), .afe(afe), .irq(irq));

  always #5 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////////////
  // Analog stand-in: comparator follows the trial code, RC clock has a 6-cycle period
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    comp_in <= (target >= afe.dac);
    rc_cnt <= (rc_cnt == 2) ? 0 : rc_cnt + 1;
    if (rc_cnt == 2) begin
      rc_osc_in <= ~rc_osc_in;
    end
    if (cyc == 30000) begin
      failures++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask

  task automatic settle;
    repeat (2) @(posedge pclk);
  endtask

  task end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(adcr_pkg::OFF_CLK_CFG, 32'h0);
    rdchk(adcr_pkg::OFF_CHAN_CTRL, 32'h0);
    rdchk(adcr_pkg::OFF_IRQ_FLAGS, 32'h0);
    rdchk(adcr_pkg::OFF_IRQ_MASK, 32'h0);
    wr(adcr_pkg::OFF_CLK_CFG, 32'hffffffff);
    rdchk(adcr_pkg::OFF_CLK_CFG, 32'h70);
    apb(1'b0, 8'h18, 32'h0);
    `CHK(er, 1'b1)
    $display("test registers done");
    for (s = 0; s < 32; s++) begin
      wr(adcr_pkg::OFF_CHAN_CTRL, (s << 2) | 1);
      settle();
      `CHK(afe.select, s[4:0])
      `CHK(afe.src_valid, (s <= 12 || (s >= 16 && s <= 23)))
      `CHK(afe.enable, 1'b1)
      `CHK(afe.sample, 1'b1)
    end
    $display("test select done");
    // Reserved clock codes never finish; software aborts by clearing go
    for (s = 0; s < 2; s++) begin
      wr(adcr_pkg::OFF_CLK_CFG, (s * 4) << 4);
      wr(adcr_pkg::OFF_CHAN_CTRL, 32'h43);
      repeat (200) @(posedge pclk);
      rdchk(adcr_pkg::OFF_CHAN_CTRL, 32'h43);
      rdchk(adcr_pkg::OFF_IRQ_FLAGS, 32'h0);
      wr(adcr_pkg::OFF_CHAN_CTRL, 32'h41);
      rdchk(adcr_pkg::OFF_CHAN_CTRL, 32'h41);
    end
    $display("test reserved done");
    for (i = 0; i < 6; i++) begin
      mask = i % 2;
      wr(adcr_pkg::OFF_IRQ_MASK, mask);
      wr(adcr_pkg::OFF_CLK_CFG, codes[i] << 4);
      rdchk(adcr_pkg::OFF_CLK_CFG, codes[i] << 4);
      wr(adcr_pkg::OFF_CHAN_CTRL, 32'h41);
      repeat (50) @(posedge pclk);
      target = (i == 0) ? 0 : (i == 1) ? 1023 : ($random(seed) & 32'h3ff);
      q.push_back(target);
      wr(adcr_pkg::OFF_CHAN_CTRL, 32'h43);
      t0 = cyc;
      rdchk(adcr_pkg::OFF_CHAN_CTRL, 32'h43);
      `CHK(afe.sample, 1'b0)
      do begin
        apb(1'b0, adcr_pkg::OFF_CHAN_CTRL, 32'h0);
      end while (rd[1] === 1'b1);
      dur = cyc - t0;
      `CHK(dur >= 9 * divs[i] && dur <= 11 * divs[i] + 12, 1'b1)
      `CHK(rd, 32'h41)
      expv = q.pop_front();
      last = expv;
      rdchk(adcr_pkg::OFF_RES_HIGH, expv >> 8);
      rdchk(adcr_pkg::OFF_RES_LOW, expv & 255);
      rdchk(adcr_pkg::OFF_IRQ_FLAGS, 32'h1);
      `CHK(irq, mask[0])
      wr(adcr_pkg::OFF_IRQ_FLAGS, 32'h1);
      settle();
      `CHK(irq, 1'b0)
      rdchk(adcr_pkg::OFF_IRQ_FLAGS, 32'h0);
      $display("test conversion %0d done", i);
    end
    wr(adcr_pkg::OFF_RES_LOW, 32'hff);
    wr(adcr_pkg::OFF_RES_HIGH, 32'h3);
    rdchk(adcr_pkg::OFF_RES_LOW, last & 255);
    rdchk(adcr_pkg::OFF_RES_HIGH, last >> 8);
    wr(adcr_pkg::OFF_CHAN_CTRL, 32'h0);
    settle();
    `CHK(afe.enable, 1'b0)
    `CHK(afe.dac, 10'h000)
    `CHK(afe.sample, 1'b0)
    $display("test readonly and disable done");
    end_sim();
  end
endmodule
`default_nettype wire
